//--- design/ptas_pkg.sv
// package for the target address and chip-select register block
// assumes a single 20 MHz clock and a plain strobe register port
package ptas_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] PTAS_OFF_TARGET = 4'h0; // target_address_select
   localparam logic [3:0] PTAS_OFF_CTRL = 4'h4;   // port_control_register mode copy
   localparam logic [3:0] PTAS_OFF_RADDR = 4'h8;  // split read address
   localparam logic [3:0] PTAS_OFF_WADDR = 4'hc;  // split write address
   localparam logic [3:0] PTAS_OFF_RDIN = 4'h0;   // unused alias guard

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PTAS_BIT_SEC2 = 23;
   localparam int PTAS_BIT_SEC1 = 22;
   localparam int PTAS_BIT_SEL2 = 15;
   localparam int PTAS_BIT_SEL1 = 14;
   localparam int PTAS_CTRL_MODE_LO = 0;  // select_mode_field bits 1:0
   localparam int PTAS_CTRL_EXT = 2;      // extended_location_enable
   localparam int PTAS_CTRL_SPLIT = 17;   // split_buffer_enable

   // ----------------------------------------
   // reset values and masks
   // ----------------------------------------
   localparam logic [31:0] PTAS_TARGET_RESET = 32'h0000_0000;
   localparam logic [31:0] PTAS_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] PTAS_TARGET_MASK = 32'h00ff_ffff;
   localparam logic [31:0] PTAS_CTRL_MASK = 32'h0002_0007;

   // select_mode_field encodings
   localparam logic [1:0] PTAS_MODE_ADDR = 2'h0;
   localparam logic [1:0] PTAS_MODE_ONE = 2'h1;
   localparam logic [1:0] PTAS_MODE_TWO = 2'h2;

endpackage

//--- design/ptas_word_reg.sv
// one masked 32-bit software register
// assumes writes are single-cycle strobes on mclk
`timescale 1ns/1ps
`default_nettype none
module ptas_word_reg
#(
   parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
   parameter logic [31:0] WRITE_MASK = 32'hffff_ffff
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // write side
   input wire logic wr,
   input wire logic [31:0] wdata,
   // stored word
   output logic [31:0] value
);

   // unmasked bits stay at reset value
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         value <= RESET_VALUE;
      end
      else if (wr)
      begin
         value <= (wdata & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
      end
   end

endmodule
`default_nettype wire

//--- design/ptas_rd_mux.sv
// read-data register for the software port
// assumes one read strobe per cycle at most
`timescale 1ns/1ps
`default_nettype none
module ptas_rd_mux
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // selection
   input wire logic rd,
   input wire logic [3:0] addr,
   // sources
   input wire logic [31:0] word0,
   input wire logic [31:0] word1,
   input wire logic [31:0] word2,
   input wire logic [31:0] word3,
   // answer
   output logic [31:0] rdata
);
   import ptas_pkg::*;

   // answer lands one cycle after the strobe; unmapped reads as zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rdata <= 32'h0000_0000;
      end
      else if (rd)
      begin
         case (addr)
            PTAS_OFF_TARGET: rdata <= word0;
            PTAS_OFF_CTRL: rdata <= word1;
            PTAS_OFF_RADDR: rdata <= word2;
            PTAS_OFF_WADDR: rdata <= word3;
            default: rdata <= 32'h0000_0000;
         endcase
      end
      else
      begin
         rdata <= 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

//--- design/ptas_top.sv
// target address and chip-select register of the parallel master port
// assumes the transfer sequencer samples the decoded outputs per transfer
`timescale 1ns/1ps
`default_nettype none
module ptas_top
   import ptas_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // transfer side
   input wire logic xfer_is_read,
   input wire logic rd_capture,
   input wire logic [15:0] rd_capture_data,
   // decoded outputs and captured read data
   output logic [23:0] target_location,
   output logic select_one_enable,
   output logic select_two_enable,
   output logic secondary_select_one_enable,
   output logic secondary_select_two_enable,
   output logic [15:0] split_read_data_register,
   output logic [15:0] shared_port_data_register
);
   import ptas_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [31:0] target_address_select;
   logic [31:0] port_control_register;
   logic [31:0] split_raddr;
   logic [31:0] split_waddr;

   // top byte is never writable
   ptas_word_reg #(.RESET_VALUE(PTAS_TARGET_RESET), .WRITE_MASK(PTAS_TARGET_MASK)) u_target
   (
      .mclk(mclk),
      .rst(rst),
      .wr(reg_wr && reg_addr == PTAS_OFF_TARGET),
      .wdata(reg_wdata),
      .value(target_address_select)
   );

   // mode bits copy of the port control
   ptas_word_reg #(.RESET_VALUE(PTAS_CTRL_RESET), .WRITE_MASK(PTAS_CTRL_MASK)) u_ctrl
   (
      .mclk(mclk),
      .rst(rst),
      .wr(reg_wr && reg_addr == PTAS_OFF_CTRL),
      .wdata(reg_wdata),
      .value(port_control_register)
   );

   // split read address
   ptas_word_reg #(.RESET_VALUE(PTAS_TARGET_RESET), .WRITE_MASK(PTAS_TARGET_MASK)) u_raddr
   (
      .mclk(mclk),
      .rst(rst),
      .wr(reg_wr && reg_addr == PTAS_OFF_RADDR),
      .wdata(reg_wdata),
      .value(split_raddr)
   );

   // split write address
   ptas_word_reg #(.RESET_VALUE(PTAS_TARGET_RESET), .WRITE_MASK(PTAS_TARGET_MASK)) u_waddr
   (
      .mclk(mclk),
      .rst(rst),
      .wr(reg_wr && reg_addr == PTAS_OFF_WADDR),
      .wdata(reg_wdata),
      .value(split_waddr)
   );

   // read-back of all four words
   ptas_rd_mux u_rd
   (
      .mclk(mclk),
      .rst(rst),
      .rd(reg_rd),
      .addr(reg_addr),
      .word0(target_address_select),
      .word1(port_control_register),
      .word2(split_raddr),
      .word3(split_waddr),
      .rdata(reg_rdata)
   );

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   logic [1:0] select_mode_field;
   logic extended_location_enable;
   logic split_buffer_enable;
   logic mode_select;
   logic [31:0] src;

   assign select_mode_field = port_control_register[PTAS_CTRL_MODE_LO +: 2];
   assign extended_location_enable = port_control_register[PTAS_CTRL_EXT];
   assign split_buffer_enable = port_control_register[PTAS_CTRL_SPLIT];
   assign mode_select = (select_mode_field == PTAS_MODE_ONE) ||
                        (select_mode_field == PTAS_MODE_TWO);

   // source word: shared register or split registers per direction
   always_comb
   begin
      if (!split_buffer_enable)
      begin
         src = target_address_select;
      end
      else if (xfer_is_read)
      begin
         src = split_raddr;
      end
      else
      begin
         src = split_waddr;
      end
   end

   // ----------------------------------------
   // decoded location and selects
   // ----------------------------------------
   logic [23:0] next_location;
   logic next_sel1;
   logic next_sel2;
   logic next_sec1;
   logic next_sec2;

   // split mode takes only location bits 15:0 from the split registers
   always_comb
   begin
      next_location = 24'h00_0000;
      next_location[13:0] = src[13:0];
      next_sel1 = 1'b0;
      next_sel2 = 1'b0;
      next_sec1 = 1'b0;
      next_sec2 = 1'b0;
      if (mode_select || !extended_location_enable)
      begin
         next_sel1 = src[PTAS_BIT_SEL1];
      end
      if (select_mode_field != PTAS_MODE_TWO || extended_location_enable)
      begin
         next_location[14] = src[PTAS_BIT_SEL1] & ~next_sel1;
      end
      if (mode_select && !extended_location_enable)
      begin
         next_sel2 = src[PTAS_BIT_SEL2];
      end
      else
      begin
         next_location[15] = src[PTAS_BIT_SEL2];
      end
      if (extended_location_enable && !split_buffer_enable)
      begin
         next_location[21:16] = src[21:16];
      end
      if (mode_select)
      begin
         next_sec2 = src[PTAS_BIT_SEC2];
      end
      if (select_mode_field == PTAS_MODE_TWO)
      begin
         next_sec1 = src[PTAS_BIT_SEC1];
      end
      if (select_mode_field == PTAS_MODE_ADDR && extended_location_enable &&
          !split_buffer_enable)
      begin
         next_location[23:22] = src[23:22];
      end
   end

   // registered decode outputs
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         target_location <= 24'h00_0000;
         select_one_enable <= 1'b0;
         select_two_enable <= 1'b0;
         secondary_select_one_enable <= 1'b0;
         secondary_select_two_enable <= 1'b0;
      end
      else
      begin
         target_location <= next_location;
         select_one_enable <= next_sel1;
         select_two_enable <= next_sel2;
         secondary_select_one_enable <= next_sec1;
         secondary_select_two_enable <= next_sec2;
      end
   end

   // ----------------------------------------
   // captured read data routing
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         split_read_data_register <= 16'h0000;
         shared_port_data_register <= 16'h0000;
      end
      else if (rd_capture)
      begin
         if (split_buffer_enable)
         begin
            split_read_data_register <= rd_capture_data;
         end
         else
         begin
            shared_port_data_register <= rd_capture_data;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_top_zero;
      @(posedge mclk) disable iff (rst)
      reg_rd ##1 1'b1 |-> reg_rdata[31:24] == 8'h00;
   endproperty
   a_top_zero: assert property (p_top_zero) else $error("top byte not zero");

   property p_sec2;
      @(posedge mclk) disable iff (rst)
      !mode_select |=> !secondary_select_two_enable;
   endproperty
   a_sec2: assert property (p_sec2) else $error("sec two enable outside mode");

   property p_upper;
      @(posedge mclk) disable iff (rst)
      (select_mode_field != PTAS_MODE_ADDR) |=> target_location[23:22] == 2'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper bits wrongly used");

   property p_sec1;
      @(posedge mclk) disable iff (rst)
      (select_mode_field == PTAS_MODE_TWO) |=> secondary_select_one_enable == $past(src[22]);
   endproperty
   a_sec1: assert property (p_sec1) else $error("sec one enable wrong");

   property p_mid;
      @(posedge mclk) disable iff (rst)
      !extended_location_enable |=> target_location[21:16] == 6'h00;
   endproperty
   a_mid: assert property (p_mid) else $error("mid bits used without ext");

   property p_sel2;
      @(posedge mclk) disable iff (rst)
      (mode_select && !extended_location_enable) |=> select_two_enable == $past(src[15]);
   endproperty
   a_sel2: assert property (p_sel2) else $error("select two wrong");

   property p_low;
      @(posedge mclk) disable iff (rst)
      1'b1 |=> target_location[13:0] == $past(src[13:0]);
   endproperty
   a_low: assert property (p_low) else $error("low address wrong");

   property p_shared;
      @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == PTAS_OFF_TARGET && !split_buffer_enable) ##1
      !split_buffer_enable |=> target_location[13:0] == $past(reg_wdata[13:0], 2);
   endproperty
   a_shared: assert property (p_shared) else $error("shared address not used");

   property p_capture;
      @(posedge mclk) disable iff (rst)
      (rd_capture && split_buffer_enable) |=>
      split_read_data_register == $past(rd_capture_data) && $stable(shared_port_data_register);
   endproperty
   a_capture: assert property (p_capture) else $error("split capture wrong");

endmodule
`default_nettype wire

//--- bench/ptas_far_device.sv
// model of the external parallel target that answers read transfers
// assumes the bench pulses req once per read and sets wait_cycles
`timescale 1ns/1ps
`default_nettype none
module ptas_far_device
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // transfer request
   input wire logic req,
   input wire logic [3:0] wait_cycles,
   input wire logic [23:0] loc,
   // returned data
   output logic rd_capture,
   output logic [15:0] rd_capture_data
);
   logic [3:0] cnt;
   logic busy;

   // ------------------------------
   // answer after wait_cycles; data toggles outside the answer cycle
   // ------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         cnt <= 4'h0;
         rd_capture <= 1'b0;
         rd_capture_data <= 16'h0000;
      end
      else if (req)
      begin
         busy <= 1'b1;
         cnt <= wait_cycles;
         rd_capture <= 1'b0;
         rd_capture_data <= ~rd_capture_data;
      end
      else if (busy && cnt == 4'h0)
      begin
         busy <= 1'b0;
         rd_capture <= 1'b1;
         rd_capture_data <= loc[15:0] ^ 16'ha5c3; // contents seen at the address
      end
      else
      begin
         cnt <= cnt - 4'h1;
         rd_capture <= 1'b0;
         rd_capture_data <= ~rd_capture_data; // released bus: no stale value
      end
   end
endmodule
`default_nettype wire

//--- bench/test_ptas_top.sv
// self-checking bench for the target address and select register
// assumes the design package and the far device model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_ptas_top
   import ptas_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic xfer_is_read = 1'b0;
   logic req = 1'b0;
   logic [3:0] wait_cycles = 4'h0;
   logic [31:0] reg_rdata;
   logic rd_capture;
   logic [15:0] rd_capture_data;
   logic [23:0] target_location;
   logic sel1, sel2, sec1, sec2;
   logic [15:0] split_rd, shared_rd;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;

   // ------------------------------
   // clock, design and far device
   // ------------------------------
   always #25 mclk = ~mclk;

   ptas_top ptas_top_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .xfer_is_read(xfer_is_read), .rd_capture(rd_capture),
      .rd_capture_data(rd_capture_data), .target_location(target_location),
      .select_one_enable(sel1), .select_two_enable(sel2),
      .secondary_select_one_enable(sec1), .secondary_select_two_enable(sec2),
      .split_read_data_register(split_rd), .shared_port_data_register(shared_rd));

   ptas_far_device ptas_far_device_inst (.mclk(mclk), .rst(rst), .req(req),
      .wait_cycles(wait_cycles), .loc(target_location), .rd_capture(rd_capture),
      .rd_capture_data(rd_capture_data));

   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic wrap_up;
      if (n_fail == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
      @(posedge mclk);
      #1;
      chk(reg_rdata, 32'h0); // data stands one cycle only
   endtask

   // decoded outputs three edges after the write, selects as {sec2,sec1,sel2,sel1}
   task automatic outs(input logic [23:0] l, input logic [23:0] m, input logic [3:0] s);
      repeat (3) @(posedge mclk);
      #1;
      chk({8'h00, target_location & m}, {8'h00, l});
      chk({28'h0, sec2, sec1, sel2, sel1}, {28'h0, s});
   endtask

   task automatic cap(input logic [3:0] w);
      int k;
      @(posedge mclk);
      wait_cycles <= w;
      req <= 1'b1;
      @(posedge mclk);
      req <= 1'b0;
      for (k = 0; k < 40 && rd_capture !== 1'b1; k++)
      begin
         @(posedge mclk);
         #1;
      end
      chk({31'h0, rd_capture}, 32'h1);
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_reset;
      #1;
      outs(24'h0, 24'hffffff, 4'h0);
      chk({split_rd, shared_rd}, 32'h0);
      rd_chk(PTAS_OFF_TARGET, 32'h0);
   endtask

   task automatic t_refuse;
      wr(PTAS_OFF_TARGET, 32'hffff_ffff);
      rd_chk(PTAS_OFF_TARGET, 32'h00ff_ffff);
      wr(PTAS_OFF_CTRL, 32'hffff_ffff);
      rd_chk(PTAS_OFF_CTRL, PTAS_CTRL_MASK);
      rd_chk(4'h2, 32'h0);
   endtask

   task automatic t_addr;
      wr(PTAS_OFF_CTRL, 32'h0000_0004);
      wr(PTAS_OFF_TARGET, 32'hffff_ffff);
      outs(24'hffffff, 24'hffffff, 4'h0);
      wr(PTAS_OFF_CTRL, 32'h0000_0000);
      outs(24'h00bfff, 24'hffffff, 4'h1);
   endtask

   task automatic t_modes;
      wr(PTAS_OFF_CTRL, 32'h0000_0002);
      wr(PTAS_OFF_TARGET, 32'h00c0_d234);
      outs(24'h001234, 24'hffffff, 4'hf);
      wr(PTAS_OFF_TARGET, 32'h0000_3fff);
      outs(24'h003fff, 24'hffffff, 4'h0);
      wr(PTAS_OFF_CTRL, 32'h0000_0001);
      wr(PTAS_OFF_TARGET, 32'h00ff_ffff);
      outs(24'h003fff, 24'hffffff, 4'hb);
   endtask

   task automatic t_split;
      wr(PTAS_OFF_CTRL, 32'h0002_0002);
      wr(PTAS_OFF_RADDR, 32'h0040_0011);
      wr(PTAS_OFF_WADDR, 32'h0080_0022);
      wr(PTAS_OFF_TARGET, 32'h00ff_ffff);
      xfer_is_read <= 1'b1;
      outs(24'h000011, 24'hffffff, 4'h4);
      @(posedge mclk);
      xfer_is_read <= 1'b0;
      outs(24'h000022, 24'hffffff, 4'h8);
      wr(PTAS_OFF_CTRL, 32'h0000_0002);
      wr(PTAS_OFF_TARGET, 32'h0000_0123);
      outs(24'h000123, 24'hffffff, 4'h0);
      @(posedge mclk);
      xfer_is_read <= 1'b1;
      outs(24'h000123, 24'hffffff, 4'h0);
   endtask

   task automatic t_capture;
      cap(4'h0);
      chk({split_rd, shared_rd}, 32'h0000_a4e0);
      wr(PTAS_OFF_CTRL, 32'h0002_0002);
      outs(24'h000011, 24'hffffff, 4'h4);
      cap(4'h5);
      chk({split_rd, shared_rd}, 32'ha5d2_a4e0);
      // extended on with split on: upper and middle bits stay off the address
      wr(PTAS_OFF_RADDR, 32'h007f_0011);
      wr(PTAS_OFF_CTRL, 32'h0002_0004);
      outs(24'h000011, 24'hffffff, 4'h0);
   endtask

   // mid-run reset after the registers hold non-zero contents
   task automatic t_rerst;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
   endtask

   // ------------------------------
   // hang guard and main sequence
   // ------------------------------
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_refuse();
      t_addr();
      t_modes();
      t_split();
      t_capture();
      t_rerst();
      wrap_up();
   end
endmodule
`default_nettype wire
